// ==== src/slci_regs.vh ====
// Constants for the serial display command interface
`ifndef SLCI_REGS_VH
`define SLCI_REGS_VH

// Link bit framing
`define SLCI_BITS_PER_BYTE 4'h8
`define SLCI_LAST_BIT_IDX 3'h7

// Address limits
`define SLCI_COL_LAST 7'h65
`define SLCI_BANK_LAST 4'h8

// Reset values
`define SLCI_RST_SLEEP 1'b1
`define SLCI_RST_SCAN 1'b0
`define SLCI_RST_EXT 1'b0
`define SLCI_RST_MODE 2'h0
`define SLCI_RST_COL 7'h00
`define SLCI_RST_BANK 4'h0
`define SLCI_RST_SLOPE 2'h0
`define SLCI_RST_PUMP 2'h0
`define SLCI_RST_BIAS 3'h0
`define SLCI_RST_OP 7'h00
`define SLCI_RST_RANGE 1'b0

// Display mode codes, frame_on_bit then pix_fill_bit
`define SLCI_MODE_BLANK 2'h0
`define SLCI_MODE_NORMAL 2'h2
`define SLCI_MODE_ALL_ON 2'h1
`define SLCI_MODE_INVERSE 2'h3

// Command opcode fields
`define SLCI_OP_NOP 8'h00
`define SLCI_OP_FUNC_HI 5'h04
`define SLCI_OP_DISP_HI 5'h01
`define SLCI_OP_RANGE_HI 7'h08
`define SLCI_OP_BANK_HI 4'h4
`define SLCI_OP_SLOPE_HI 6'h01
`define SLCI_OP_PUMP_HI 6'h02
`define SLCI_OP_BIAS_HI 5'h02

// Link clock period in the bench, ns
`define SLCI_LINK_PERIOD_NS 125

`endif

// ==== src/slci_core.v ====
// Serial display command interface: receiver, byte FIFO and command decoder
//
// Functional notes
// R1: Chip select high resets receiver, ignores clocks
// R2: Chip select falling edge starts new byte
// R3: Sample data on clock rise, MSB first
// R4: Mode line sampled at eighth bit
// R5: Back-to-back bytes need no gap
// R6: Last bit latched by clock edge or deselect; code latches only on the eighth clock rise, deselect drops the byte
// R7: Hard clear aborts byte, clears registers
// R8: After hard clear, next edge is first_bit
// R9: Address advances after each data write
// R10: Zero byte no-op; function set loads bits
// R11: ext_set_sel chooses basic or extended set
// R12: Display control sets four display modes
// R13: Range command loads range_hi_sel
// R14: Bank command loads bank_pointer 0 to 8
// R15: Column command loads column_pointer 0 to 101
// R16: Extended slope command loads temp_slope_sel
// R17: Extended pump command loads pump_factor
// R18: Extended bias command loads bias_ratio
// R19: Extended level command loads op_level
// R20: Reset values; memory left untouched
// R21: Generator off while level and range zero
// R22: Sleep grounds outputs, keeps interface alive
// R23: Bank 8 write stores only the LSB
// R24: scan_order_bit picks addressing direction
// R25: Vertical: bank wraps past 8, column increments
// R26: Horizontal: column wraps past 101, bank increments
// R27: Last location wraps both pointers to zero
// R28: Reserved codes cause no defined change
// R29: Command decoded with previous ext_set_sel
`timescale 1ns/100ps
`default_nettype none
`include "slci_regs.vh"

// ----------------------------------------
// Byte FIFO between link and decoder
// ----------------------------------------
module slci_fifo #(
   parameter WIDTH = 9,
   parameter DEPTH = 8,
   parameter AW = 3
) (
   input wire clk_sys_in,
   input wire rst_n_in,
   input wire in_valid_in,
   output wire in_ready_out,
   input wire [WIDTH-1:0] in_data_in,
   output wire out_valid_out,
   input wire out_ready_in,
   output wire [WIDTH-1:0] out_data_out
);
   reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
   reg [AW:0] wr_ptr_reg;
   reg [AW:0] rd_ptr_reg;
   wire empty;
   wire full;

   // Full when pointers differ only in wrap bit
   assign empty = (wr_ptr_reg == rd_ptr_reg);
   assign full = (wr_ptr_reg[AW] != rd_ptr_reg[AW]) && (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]);
   assign in_ready_out = ~full;
   assign out_valid_out = ~empty;
   assign out_data_out = mem_reg[rd_ptr_reg[AW-1:0]];

   // Storage write
   always @(posedge clk_sys_in) begin
      if (in_valid_in && !full) begin
         mem_reg[wr_ptr_reg[AW-1:0]] <= in_data_in;
      end
   end

   // Pointer update
   always @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         wr_ptr_reg <= {(AW+1){1'b0}};
         rd_ptr_reg <= {(AW+1){1'b0}};
      end else begin
         if (in_valid_in && !full) begin
            wr_ptr_reg <= wr_ptr_reg + 1'b1;
         end
         if (out_ready_in && !empty) begin
            rd_ptr_reg <= rd_ptr_reg + 1'b1;
         end
      end
   end
endmodule // slci_fifo

// ----------------------------------------
// Top level
// ----------------------------------------
module slci_core #(
   parameter FIFO_DEPTH = 8,
   parameter FIFO_AW = 3
) (
   input wire clk_sys_in,
   input wire rst_n_in,
   // Serial link pins
   input wire shift_clock_in,
   input wire chip_select_n_in,
   input wire serial_in_in,
   input wire cmd_or_data_in,
   input wire hard_clear_n_in,
   // Display memory write port
   output wire mem_we_out,
   input wire mem_ready_in,
   output wire [3:0] mem_bank_out,
   output wire [6:0] mem_col_out,
   output wire [7:0] mem_data_out,
   output wire mem_bit_only_out,
   // Configuration state
   output wire sleep_bit_out,
   output wire scan_order_bit_out,
   output wire ext_set_sel_out,
   output wire frame_on_bit_out,
   output wire pix_fill_bit_out,
   output wire range_hi_sel_out,
   output wire [3:0] bank_pointer_out,
   output wire [6:0] column_pointer_out,
   output wire [1:0] temp_slope_sel_out,
   output wire [1:0] pump_factor_out,
   output wire [2:0] bias_ratio_out,
   output wire [6:0] op_level_out,
   // Analog enables
   output wire gen_enable_out,
   output wire display_drive_en_out,
   output wire osc_enable_out,
   // Link status
   output wire link_ready_out,
   output wire overrun_out
);
   reg [1:0] sclk_sync_reg;
   reg [1:0] cs_sync_reg;
   reg [1:0] serial_in_sync_reg;
   reg [1:0] dc_sync_reg;
   reg [1:0] clr_sync_reg;
   reg sclk_prev_reg;
   reg cs_prev_reg;
   reg [2:0] bit_cnt_reg;
   reg [6:0] shift_reg;
   reg push_reg;
   reg [8:0] push_data_reg;
   reg overrun_reg;
   reg sleep_reg;
   reg scan_reg;
   reg ext_reg;
   reg [1:0] mode_reg;
   reg range_reg;
   reg [3:0] bank_reg;
   reg [6:0] col_reg;
   reg [1:0] slope_reg;
   reg [1:0] pump_reg;
   reg [2:0] bias_reg;
   reg [6:0] op_reg;
   reg we_reg;
   reg [3:0] wr_bank_reg;
   reg [6:0] wr_col_reg;
   reg [7:0] wr_data_reg;
   reg bit_only_reg;
   wire sclk_s;
   wire cs_n_s;
   wire clr_n_s;
   wire sclk_rise;
   wire cs_fall;
   wire live;
   wire fifo_in_ready;
   wire fifo_out_valid;
   wire fifo_out_ready;
   wire [8:0] fifo_out_data;
   wire pop;
   wire is_data;
   wire [7:0] byte_v;

   // Two-stage synchronisers for all serial link pins, edge history of clock and select
   always @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         sclk_sync_reg <= 2'h0;
         cs_sync_reg <= 2'h3;
         serial_in_sync_reg <= 2'h0;
         dc_sync_reg <= 2'h0;
         clr_sync_reg <= 2'h0;
         sclk_prev_reg <= 1'b0;
         cs_prev_reg <= 1'b1;
      end else begin
         sclk_sync_reg <= {sclk_sync_reg[0], shift_clock_in};
         cs_sync_reg <= {cs_sync_reg[0], chip_select_n_in};
         serial_in_sync_reg <= {serial_in_sync_reg[0], serial_in_in};
         dc_sync_reg <= {dc_sync_reg[0], cmd_or_data_in};
         clr_sync_reg <= {clr_sync_reg[0], hard_clear_n_in};
         sclk_prev_reg <= sclk_sync_reg[1];
         cs_prev_reg <= cs_sync_reg[1];
      end
   end

   assign sclk_s = sclk_sync_reg[1];
   assign cs_n_s = cs_sync_reg[1];
   assign clr_n_s = clr_sync_reg[1];
   // Hard clear acts as a second synchronous reset
   assign live = rst_n_in & clr_n_s; // see R7
   assign sclk_rise = sclk_s & ~sclk_prev_reg;
   assign cs_fall = cs_prev_reg & ~cs_n_s;

   // ----------------------------------------
   // Serial receiver
   // ----------------------------------------
   // Bits shift in MSB first; eighth bit completes the byte
   always @(posedge clk_sys_in) begin
      if (!live) begin
         bit_cnt_reg <= 3'h0; // see R8
         shift_reg <= 7'h00;
         push_reg <= 1'b0;
         push_data_reg <= 9'h000;
      end else begin
         push_reg <= 1'b0;
         if (cs_n_s || cs_fall) begin
            bit_cnt_reg <= 3'h0; // see R1, R2
         end else if (sclk_rise) begin
            shift_reg <= {shift_reg[5:0], serial_in_sync_reg[1]}; // see R3
            if (bit_cnt_reg == `SLCI_LAST_BIT_IDX) begin
               // Mode line taken with the final bit
               push_reg <= 1'b1; // see R4, R6
               push_data_reg <= {dc_sync_reg[1], shift_reg, serial_in_sync_reg[1]};
               bit_cnt_reg <= 3'h0; // see R5
            end else begin
               bit_cnt_reg <= bit_cnt_reg + 3'h1;
            end
         end
      end
   end

   // Byte lost when the FIFO is full
   always @(posedge clk_sys_in) begin
      if (!live) begin
         overrun_reg <= 1'b0;
      end else if (push_reg && !fifo_in_ready) begin
         overrun_reg <= 1'b1;
      end
   end

   // Byte FIFO, flushed by reset and hard clear
   slci_fifo #(.WIDTH(9), .DEPTH(FIFO_DEPTH), .AW(FIFO_AW)) u_fifo (
      .clk_sys_in(clk_sys_in),
      .rst_n_in(live),
      .in_valid_in(push_reg),
      .in_ready_out(fifo_in_ready),
      .in_data_in(push_data_reg),
      .out_valid_out(fifo_out_valid),
      .out_ready_in(fifo_out_ready),
      .out_data_out(fifo_out_data)
   );

   // ----------------------------------------
   // Decoder and address counter
   // ----------------------------------------
   assign is_data = fifo_out_data[8];
   assign byte_v = fifo_out_data[7:0];
   // Data bytes wait for the memory port
   assign fifo_out_ready = live & (~is_data | mem_ready_in);
   assign pop = fifo_out_valid & fifo_out_ready;

   // Command execution and pointer advance
   always @(posedge clk_sys_in) begin
      if (!live) begin
         sleep_reg <= `SLCI_RST_SLEEP; // see R20
         scan_reg <= `SLCI_RST_SCAN;
         ext_reg <= `SLCI_RST_EXT;
         mode_reg <= `SLCI_RST_MODE;
         range_reg <= `SLCI_RST_RANGE; // see R21
         bank_reg <= `SLCI_RST_BANK;
         col_reg <= `SLCI_RST_COL;
         slope_reg <= `SLCI_RST_SLOPE;
         pump_reg <= `SLCI_RST_PUMP;
         bias_reg <= `SLCI_RST_BIAS;
         op_reg <= `SLCI_RST_OP; // see R21
         we_reg <= 1'b0;
         wr_bank_reg <= 4'h0;
         wr_col_reg <= 7'h00;
         wr_data_reg <= 8'h00;
         bit_only_reg <= 1'b0;
      end else begin
         we_reg <= 1'b0;
         if (pop && is_data) begin
            // Memory write, still allowed in sleep
            we_reg <= 1'b1; // see R22
            wr_bank_reg <= bank_reg;
            wr_col_reg <= col_reg;
            bit_only_reg <= (bank_reg == `SLCI_BANK_LAST); // see R23
            wr_data_reg <= (bank_reg == `SLCI_BANK_LAST) ? {7'h00, byte_v[0]} : byte_v;
            // Advance per scan order, see R9
            if (scan_reg) begin // see R24
               if (bank_reg == `SLCI_BANK_LAST) begin
                  bank_reg <= 4'h0; // see R25
                  col_reg <= (col_reg == `SLCI_COL_LAST) ? 7'h00 : col_reg + 7'h01; // see R27
               end else begin
                  bank_reg <= bank_reg + 4'h1;
               end
            end else begin
               if (col_reg == `SLCI_COL_LAST) begin
                  col_reg <= 7'h00; // see R26
                  bank_reg <= (bank_reg == `SLCI_BANK_LAST) ? 4'h0 : bank_reg + 4'h1; // see R27
               end else begin
                  col_reg <= col_reg + 7'h01;
               end
            end
         end else if (pop) begin
            // Decode uses ext_reg as it stood before this byte, see R29
            if (byte_v == `SLCI_OP_NOP) begin
               sleep_reg <= sleep_reg; // see R10
            end else if ((byte_v[7:3] == `SLCI_OP_FUNC_HI)) begin
               sleep_reg <= byte_v[2]; // see R10
               scan_reg <= byte_v[1];
               ext_reg <= byte_v[0];
            end else if (!ext_reg) begin // see R11
               if (byte_v[7]) begin
                  col_reg <= byte_v[6:0]; // see R15
               end else if (byte_v[7:4] == `SLCI_OP_BANK_HI) begin
                  bank_reg <= byte_v[3:0]; // see R14
               end else if (byte_v[7:1] == `SLCI_OP_RANGE_HI) begin
                  range_reg <= byte_v[0]; // see R13
               end else if ((byte_v[7:3] == `SLCI_OP_DISP_HI) && !byte_v[1]) begin
                  mode_reg <= {byte_v[2], byte_v[0]}; // see R12
               end
               // Other basic codes are reserved and ignored, see R28
            end else begin
               if (byte_v[7]) begin
                  op_reg <= byte_v[6:0]; // see R19
               end else if (byte_v[7:3] == `SLCI_OP_BIAS_HI) begin
                  bias_reg <= byte_v[2:0]; // see R18
               end else if (byte_v[7:2] == `SLCI_OP_PUMP_HI) begin
                  pump_reg <= byte_v[1:0]; // see R17
               end else if (byte_v[7:2] == `SLCI_OP_SLOPE_HI) begin
                  slope_reg <= byte_v[1:0]; // see R16
               end
               // Test and reserved codes ignored, see R28
            end
         end
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign mem_we_out = we_reg;
   assign mem_bank_out = wr_bank_reg;
   assign mem_col_out = wr_col_reg;
   assign mem_data_out = wr_data_reg;
   assign mem_bit_only_out = bit_only_reg;
   assign sleep_bit_out = sleep_reg;
   assign scan_order_bit_out = scan_reg;
   assign ext_set_sel_out = ext_reg;
   assign frame_on_bit_out = mode_reg[1];
   assign pix_fill_bit_out = mode_reg[0];
   assign range_hi_sel_out = range_reg;
   assign bank_pointer_out = bank_reg;
   assign column_pointer_out = col_reg;
   assign temp_slope_sel_out = slope_reg;
   assign pump_factor_out = pump_reg;
   assign bias_ratio_out = bias_reg;
   assign op_level_out = op_reg;
   // Generator off in sleep or with zero programming
   assign gen_enable_out = ~sleep_reg & (range_reg | (|op_reg)); // see R21, R22
   assign display_drive_en_out = ~sleep_reg; // see R22
   assign osc_enable_out = ~sleep_reg; // see R22
   assign link_ready_out = fifo_in_ready;
   assign overrun_out = overrun_reg;
endmodule // slci_core

`default_nettype wire

// ==== dv/slci_core_chk.sv ====
// Port checker for the serial display command interface
`timescale 1ns/100ps
`default_nettype none
module slci_core_chk (
   input wire clk_sys_in,
   input wire rst_n_in,
   input wire hard_clear_n_in,
   input wire mem_ready_in,
   input wire mem_we_out,
   input wire [3:0] mem_bank_out,
   input wire [6:0] mem_col_out,
   input wire [7:0] mem_data_out,
   input wire mem_bit_only_out,
   input wire sleep_bit_out,
   input wire scan_order_bit_out,
   input wire ext_set_sel_out,
   input wire range_hi_sel_out,
   input wire [3:0] bank_pointer_out,
   input wire [6:0] column_pointer_out,
   input wire [6:0] op_level_out,
   input wire gen_enable_out,
   input wire display_drive_en_out,
   input wire osc_enable_out
);
   default clocking @(posedge clk_sys_in); endclocking
   default disable iff (!rst_n_in);
   // ----------------------------------------
   // Reset, clear and analog enables
   // ----------------------------------------
   reset_vals_a: assert property (disable iff (1'b0) !rst_n_in |=> sleep_bit_out && !mem_we_out
      && bank_pointer_out == 4'h0 && column_pointer_out == 7'h00 && op_level_out == 7'h00 && !range_hi_sel_out)
      else $error("reset values wrong");
   hard_clear_a: assert property (!hard_clear_n_in [*4] |=> sleep_bit_out && !mem_we_out
      && bank_pointer_out == 4'h0 && !ext_set_sel_out) else $error("hard clear ignored");
   gen_off_a: assert property (gen_enable_out == (!sleep_bit_out && (range_hi_sel_out || op_level_out != 7'h00)))
      else $error("generator enable wrong");
   sleep_drive_a: assert property (display_drive_en_out == !sleep_bit_out && osc_enable_out == !sleep_bit_out)
      else $error("sleep drive wrong");
   // ----------------------------------------
   // Memory writes and address advance
   // ----------------------------------------
   pop_ready_a: assert property (mem_we_out |-> $past(mem_ready_in)) else $error("write while stalled");
   bit_only_a: assert property (mem_we_out |-> mem_bit_only_out == (mem_bank_out == 4'h8)
      && (!mem_bit_only_out || mem_data_out[7:1] == 7'h00)) else $error("last bank data wrong");
   horiz_step_a: assert property (mem_we_out && !scan_order_bit_out && mem_col_out != 7'h65
      |-> column_pointer_out == mem_col_out + 7'h01 && bank_pointer_out == mem_bank_out) else $error("horiz step");
   horiz_wrap_a: assert property (mem_we_out && !scan_order_bit_out && mem_col_out == 7'h65 && mem_bank_out != 4'h8
      |-> column_pointer_out == 7'h00 && bank_pointer_out == mem_bank_out + 4'h1) else $error("horiz wrap");
   vert_step_a: assert property (mem_we_out && scan_order_bit_out && mem_bank_out != 4'h8
      |-> bank_pointer_out == mem_bank_out + 4'h1 && column_pointer_out == mem_col_out) else $error("vert step");
   vert_wrap_a: assert property (mem_we_out && scan_order_bit_out && mem_bank_out == 4'h8 && mem_col_out != 7'h65
      |-> bank_pointer_out == 4'h0 && column_pointer_out == mem_col_out + 7'h01) else $error("vert wrap");
   last_wrap_a: assert property (mem_we_out && mem_bank_out == 4'h8 && mem_col_out == 7'h65
      |-> bank_pointer_out == 4'h0 && column_pointer_out == 7'h00) else $error("last wrap");
endmodule // slci_core_chk
bind slci_core slci_core_chk chk (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .hard_clear_n_in(hard_clear_n_in),
   .mem_ready_in(mem_ready_in), .mem_we_out(mem_we_out), .mem_bank_out(mem_bank_out), .mem_col_out(mem_col_out),
   .mem_data_out(mem_data_out), .mem_bit_only_out(mem_bit_only_out), .sleep_bit_out(sleep_bit_out),
   .scan_order_bit_out(scan_order_bit_out), .ext_set_sel_out(ext_set_sel_out), .range_hi_sel_out(range_hi_sel_out),
   .bank_pointer_out(bank_pointer_out), .column_pointer_out(column_pointer_out), .op_level_out(op_level_out),
   .gen_enable_out(gen_enable_out), .display_drive_en_out(display_drive_en_out), .osc_enable_out(osc_enable_out));
`default_nettype wire

// ==== dv/slci_host_model.sv ====
// Host model driving the serial write link
`timescale 1ns/100ps
`default_nettype none
module slci_host_model (
   output var logic shift_clock_out,
   output var logic chip_select_n_out,
   output var logic serial_data_out,
   output var logic cmd_or_data_out
);
   // Idle link: deselected, clock still
   initial begin
      shift_clock_out = 1'b0;
      chip_select_n_out = 1'b1;
      serial_data_out = 1'b0;
      cmd_or_data_out = 1'b0;
   end
   // Sends n bits MSB first, optionally staying selected
   task automatic bits(input logic [7:0] v, input int n, input logic d, input logic keep);
      int i;
      cmd_or_data_out = d;
      if (chip_select_n_out) begin
         chip_select_n_out = 1'b0;
         #62.5;
      end
      for (i = 0; i < n; i++) begin
         serial_data_out = v[7 - i];
         #62.5;
         shift_clock_out = 1'b1;
         #62.5;
         shift_clock_out = 1'b0;
      end
      #62.5;
      serial_data_out = ~serial_data_out; // Hold over, line no longer valid
      if (!keep) begin
         chip_select_n_out = 1'b1;
         // Deselect gap long enough to pass the select synchroniser
         #125;
      end
   endtask
endmodule // slci_host_model
`default_nettype wire

// ==== dv/tb_slci_core.sv ====
// Self-checking bench for the serial display command interface
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin mismatches++; \
   $display("Error %s expected %h seen %h", nm, e, g); end end
module tb_slci_core;
   logic clk_sys_in = 1'b0;
   logic rst_n_in = 1'b0;
   logic hard_clear_n_in = 1'b1;
   logic mem_ready_in = 1'b1;
   wire sclk, cs_n, sdi, dc, mem_we, bit_only, sleep, scan, ext, frame_on, pix_fill, range_hi;
   wire gen_en, drive_en, osc_en, link_ready, overrun;
   wire [3:0] mem_bank, bank;
   wire [6:0] mem_col, col, op;
   wire [7:0] mem_data;
   wire [1:0] slope, pump;
   wire [2:0] bias;
   logic [19:0] wq[$];
   logic full_seen = 1'b0;
   int mismatches = 0;
   int num_checks = 0;
   int cyc = 0;
   slci_host_model host (.shift_clock_out(sclk), .chip_select_n_out(cs_n), .serial_data_out(sdi),
      .cmd_or_data_out(dc));
   slci_core uut (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .shift_clock_in(sclk), .chip_select_n_in(cs_n),
      .serial_in_in(sdi), .cmd_or_data_in(dc), .hard_clear_n_in(hard_clear_n_in), .mem_we_out(mem_we),
      .mem_ready_in(mem_ready_in), .mem_bank_out(mem_bank), .mem_col_out(mem_col), .mem_data_out(mem_data),
      .mem_bit_only_out(bit_only), .sleep_bit_out(sleep), .scan_order_bit_out(scan), .ext_set_sel_out(ext),
      .frame_on_bit_out(frame_on), .pix_fill_bit_out(pix_fill), .range_hi_sel_out(range_hi), .bank_pointer_out(bank),
      .column_pointer_out(col), .temp_slope_sel_out(slope), .pump_factor_out(pump), .bias_ratio_out(bias),
      .op_level_out(op), .gen_enable_out(gen_en), .display_drive_en_out(drive_en), .osc_enable_out(osc_en),
      .link_ready_out(link_ready), .overrun_out(overrun));
   // 250 MHz clock
   initial forever #2 clk_sys_in = ~clk_sys_in;
   // Write capture, full flag and timeout
   always @(posedge clk_sys_in) begin
      cyc++;
      if (mem_we === 1'b1) wq.push_back({mem_bank, mem_col, mem_data, bit_only});
      if (link_ready === 1'b0) full_seen <= 1'b1;
      if (cyc > 60000) begin
         mismatches++;
         report_and_stop();
      end
   end
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic cmd(input logic [7:0] b);
      host.bits(b, 8, 1'b0, 1'b1);
   endtask
   task automatic dat(input logic [7:0] b);
      host.bits(b, 8, 1'b1, 1'b1);
   endtask
   task automatic settle;
      repeat (16) @(posedge clk_sys_in);
   endtask
   task automatic expw(input logic [19:0] e);
      logic [19:0] g;
      g = 20'hxxxxx;
      if (wq.size() != 0) g = wq.pop_front();
      `CHK("write", e, g)
   endtask
   task automatic t_reset;
      `CHK("config", 22'h0, {ext, scan, frame_on, pix_fill, bank, col, slope, pump, bias})
      `CHK("sleep", 3'h4, {sleep, drive_en, osc_en})
      `CHK("generator", 9'h0, {range_hi, op, gen_en})
      $display("test reset done");
   endtask
   task automatic t_basic;
      int m;
      cmd(8'h20);
      for (m = 0; m < 4; m++) begin
         cmd({5'h01, m[1], 1'b0, m[0]});
         settle();
         `CHK("mode", m[1:0], {frame_on, pix_fill})
      end
      cmd(8'h11);
      cmd(8'h48);
      cmd(8'he5);
      cmd(8'h00);
      settle();
      `CHK("range", 4'hd, {range_hi, gen_en, sleep, drive_en})
      `CHK("bank", 4'h8, bank)
      `CHK("column", 7'h65, col)
      $display("test basic done");
   endtask
   task automatic t_ext;
      int k;
      cmd(8'h21);
      for (k = 0; k < 4; k++) begin
         cmd({6'h01, k[1:0]});
         cmd({6'h02, k[1:0]});
         cmd({5'h02, 1'b1, k[1:0]});
         cmd({1'b1, 5'h0a, k[1:0]});
         settle();
         `CHK("ext", {k[1:0], k[1:0], 1'b1, k[1:0], 5'h0a, k[1:0]}, {slope, pump, bias, op})
         `CHK("column", 7'h65, col)
      end
      cmd(8'h20);
      cmd(8'h85);
      settle();
      `CHK("column", 7'h05, col)
      `CHK("level", 8'h2b, {ext, op})
      $display("test extended done");
   endtask
   task automatic t_data;
      wq.delete();
      cmd(8'h40);
      cmd(8'he4);
      dat(8'h5a);
      dat(8'h5b);
      dat(8'h5c);
      settle();
      expw({4'h0, 7'h64, 8'h5a, 1'b0});
      expw({4'h0, 7'h65, 8'h5b, 1'b0});
      expw({4'h1, 7'h00, 8'h5c, 1'b0});
      `CHK("pointers", 11'h081, {bank, col})
      cmd(8'h22);
      cmd(8'h47);
      cmd(8'h85);
      dat(8'hab);
      dat(8'hab);
      dat(8'hab);
      cmd(8'he5);
      cmd(8'h48);
      dat(8'hfe);
      settle();
      expw({4'h7, 7'h05, 8'hab, 1'b0});
      expw({4'h8, 7'h05, 8'h01, 1'b1});
      expw({4'h0, 7'h06, 8'hab, 1'b0});
      expw({4'h8, 7'h65, 8'h00, 1'b1});
      `CHK("pointers", 11'h0, {bank, col})
      $display("test data done");
   endtask
   task automatic t_fifo;
      int i;
      wq.delete();
      @(posedge clk_sys_in);
      mem_ready_in <= 1'b0;
      for (i = 0; i < 11; i++) dat(8'h10 + 8'(i));
      settle();
      `CHK("stall", 3'h7, {full_seen, overrun, wq.size() == 0})
      @(posedge clk_sys_in);
      mem_ready_in <= 1'b1;
      repeat (40) @(posedge clk_sys_in);
      `CHK("drained", 2'h3, {link_ready, wq.size() >= 8})
      expw({4'h0, 7'h00, 8'h10, 1'b0});
      expw({4'h1, 7'h00, 8'h11, 1'b0});
      $display("test fifo done");
   endtask
   task automatic t_clear;
      host.bits(8'hff, 4, 1'b0, 1'b0);
      cmd(8'h43);
      settle();
      `CHK("bank", 4'h3, bank)
      wq.delete();
      host.bits(8'hf0, 4, 1'b1, 1'b1);
      @(posedge clk_sys_in);
      hard_clear_n_in <= 1'b0;
      repeat (6) @(posedge clk_sys_in);
      hard_clear_n_in <= 1'b1;
      repeat (6) @(posedge clk_sys_in);
      `CHK("cleared", 6'h20, {sleep, bank, overrun})
      cmd(8'h46);
      host.bits(8'h5a, 8, 1'b1, 1'b0);
      settle();
      expw({4'h6, 7'h00, 8'h5a, 1'b0});
      `CHK("writes", 1'b1, wq.size() == 0)
      $display("test clear done");
   endtask
   // Main sequence
   initial begin
      repeat (3) @(posedge clk_sys_in);
      rst_n_in <= 1'b1;
      repeat (4) @(posedge clk_sys_in);
      t_reset();
      t_basic();
      t_ext();
      t_data();
      t_fifo();
      t_clear();
      report_and_stop();
   end
endmodule // tb_slci_core
`default_nettype wire
